// >>> src/fop_pkg.sv
package fop_pkg;

	// Clock and timing figures
	localparam int unsigned CLK_NS = 20;
	localparam int unsigned SIDE_PERIOD_NS = 800_000_000;
	localparam int unsigned SIDE_LOW_NS = 400_000_000;
	localparam int unsigned PULSE_PERIOD_NS = 10_000_000;
	localparam int unsigned PULSE_LOW_NS = 2_000_000;
	localparam int unsigned STRAP_SETTLE_NS = 10_000;
	localparam int unsigned SIDE_PERIOD_CYC = SIDE_PERIOD_NS / CLK_NS;
	localparam int unsigned SIDE_LOW_CYC = SIDE_LOW_NS / CLK_NS;
	localparam int unsigned PULSE_PERIOD_CYC = PULSE_PERIOD_NS / CLK_NS;
	localparam int unsigned PULSE_LOW_CYC = PULSE_LOW_NS / CLK_NS;
	// Least time, rounded up
	localparam int unsigned STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_NS - 1) / CLK_NS;

	// Register byte offsets
	localparam logic [7:0] ADDR_PIN_CFG = 8'h00;
	localparam logic [7:0] ADDR_FAIL_CTRL = 8'h04;
	localparam logic [7:0] ADDR_WAKE_ENABLE_CONTROL = 8'h08;
	localparam logic [7:0] ADDR_WAKE_LEVEL_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h18;

	// Pin configuration fields
	localparam int PC_GP1_GEN = 0;
	localparam int PC_GP1_MODE = 1;
	localparam int PC_GP2_GEN = 3;
	localparam int PC_GP2_MODE = 4;
	localparam int PC_HV_MEAS = 6;
	localparam int PC_GP1_ON = 7;
	localparam int PC_GP2_ON = 8;
	localparam int PIN_CFG_W = 9;
	localparam logic [8:0] PIN_CFG_RST = 9'h000;

	// General pin modes
	localparam logic [1:0] MODE_WAKE = 2'h0;
	localparam logic [1:0] MODE_LOW_SIDE = 2'h1;
	localparam logic [1:0] MODE_HIGH_SIDE = 2'h2;

	// Other control reset values
	localparam logic [1:0] FAIL_CTRL_RST = 2'h0;
	localparam logic [1:0] WAKE_EN_RST = 2'h3;

	// Interrupt status bits
	localparam int IRQ_WAKE1 = 0;
	localparam int IRQ_WAKE2 = 1;
	localparam int IRQ_GP1 = 2;
	localparam int IRQ_GP2 = 3;
	localparam int IRQ_FAIL = 4;
	localparam int IRQ_W = 5;
	localparam logic [4:0] IRQ_EN_RST = 5'h00;

	// Level status bits
	localparam int LS_WAKE1 = 0;
	localparam int LS_WAKE2 = 1;
	localparam int LS_GP1 = 2;
	localparam int LS_GP2 = 3;
	localparam int LS_CONFIG13 = 4;
	localparam int LS_DEV_MODE = 5;
	localparam int LS_STARTED = 6;

	// Synchronised pin indices
	localparam int PIN_INT = 0;
	localparam int PIN_WAKE1 = 1;
	localparam int PIN_WAKE2 = 2;
	localparam int PIN_GP1 = 3;
	localparam int PIN_GP2 = 4;
	localparam int PIN_N = 5;

	typedef enum logic {FOP_ST_SAMPLE, FOP_ST_RUN} fop_start_t;

endpackage

// >>> src/fop_blink.sv
`timescale 1ns/1ps
module fop_blink #(
	parameter int unsigned PERIOD_CYC = 100,
	parameter int unsigned LOW_CYC = 50
) (
	input wire logic clk,
	input wire logic rstN,
	input wire logic ce,
	input wire logic run,
	output logic lowPhase
);
	localparam int CW = $clog2(PERIOD_CYC);

	if (LOW_CYC == 0 || LOW_CYC >= PERIOD_CYC || PERIOD_CYC < 2) begin : g_bad
		$error("fop_blink: low time must be nonzero and shorter than the period");
	end

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic low_reg;
	logic low_next;

	// Free count while running, parked at zero otherwise so a pattern starts with its low phase
	always_comb begin
		cnt_next = cnt_reg;
		low_next = 1'h0;
		if (!run) begin
			cnt_next = '0;
		end else begin
			if (cnt_reg == CW'(PERIOD_CYC - 1)) begin
				cnt_next = '0;
			end else begin
				cnt_next = cnt_reg + CW'(1);
			end
			low_next = (cnt_reg < CW'(LOW_CYC));
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cnt_reg <= '0;
			low_reg <= 1'h0;
		end else if (ce) begin
			cnt_reg <= cnt_next;
			low_reg <= low_next;
		end
	end

	assign lowPhase = low_reg;
endmodule

// >>> src/fop_pin_logic.sv
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - Interrupt pin pulled low for wake-ups in stop or normal mode and for failures.
// - Interrupt pin sampled at start-up; pull-up gives config 1/3, none gives 2/4.
// - Side-indicator fail pin blinks 1.25Hz, 50% low, open drain, active low.
// - Pulsed-light fail pin blinks 100Hz, 20% low, open drain, active low.
// - Pulsed-light pin grounded at power-up selects development mode; open means normal.
// - Each fail pin can become a general pin: wake input, low-side or high-side switch.
// - After reset both dual pins act as fail outputs until software says otherwise.
// - Measurement uses wake pin one as input, pin two as output, always as a pair.
module fop_pin_logic #(
	parameter int unsigned SIDE_PERIOD_CYC = fop_pkg::SIDE_PERIOD_CYC,
	parameter int unsigned SIDE_LOW_CYC = fop_pkg::SIDE_LOW_CYC,
	parameter int unsigned PULSE_PERIOD_CYC = fop_pkg::PULSE_PERIOD_CYC,
	parameter int unsigned PULSE_LOW_CYC = fop_pkg::PULSE_LOW_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic stopOrNormal,
	input wire logic failDetect,
	input wire logic intPinIn,
	output logic intPinOut,
	output logic intPinOeN,
	input wire logic wakeInputOne,
	input wire logic wakeInputTwo,
	output logic hvMeasureSelect,
	input wire logic sideIndicatorFailIn,
	output logic sideIndicatorFailOut,
	output logic sideIndicatorFailOeN,
	input wire logic pulsedLightFailIn,
	output logic pulsedLightFailOut,
	output logic pulsedLightFailOeN,
	output logic generalPinOneHsOn,
	output logic generalPinTwoHsOn,
	output logic configOneThree,
	output logic devMode,
	output logic irq
);
	// Address decode for the error answer
	function automatic logic addrMapped(input logic [7:0] a);
		addrMapped = (a == fop_pkg::ADDR_PIN_CFG) || (a == fop_pkg::ADDR_FAIL_CTRL) ||
			(a == fop_pkg::ADDR_WAKE_ENABLE_CONTROL) || (a == fop_pkg::ADDR_WAKE_LEVEL_STATUS) ||
			(a == fop_pkg::ADDR_IRQ_STAT) || (a == fop_pkg::ADDR_IRQ_CLR) ||
			(a == fop_pkg::ADDR_IRQ_EN);
	endfunction

	// Reset release through two flops
	logic [1:0] rstSync_reg;
	logic rstN;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync_reg <= 2'h0;
		end else if (ce) begin
			rstSync_reg <= {rstSync_reg[0], 1'h1};
		end
	end
	assign rstN = rstSync_reg[1];

	// Pin synchronisers; a change counts once stages two and three agree
	logic [fop_pkg::PIN_N-1:0] pinRaw;
	logic [fop_pkg::PIN_N-1:0] s1_reg;
	logic [fop_pkg::PIN_N-1:0] s2_reg;
	logic [fop_pkg::PIN_N-1:0] s3_reg;
	logic [fop_pkg::PIN_N-1:0] filt_reg;
	logic [fop_pkg::PIN_N-1:0] filt_next;
	assign pinRaw = {pulsedLightFailIn, sideIndicatorFailIn, wakeInputTwo, wakeInputOne, intPinIn};
	always_comb begin
		filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
	end
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			s1_reg <= '1;
			s2_reg <= '1;
			s3_reg <= '1;
			filt_reg <= '1;
		end else if (ce) begin
			s1_reg <= pinRaw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= filt_next;
		end
	end

	// Start-up strap sampling; pins stay released until the straps are caught
	fop_pkg::fop_start_t st_reg;
	fop_pkg::fop_start_t st_next;
	logic [9:0] settle_reg;
	logic [9:0] settle_next;
	logic cfg13_reg;
	logic cfg13_next;
	logic dev_reg;
	logic dev_next;
	logic started;
	always_comb begin
		st_next = st_reg;
		settle_next = settle_reg;
		cfg13_next = cfg13_reg;
		dev_next = dev_reg;
		case (st_reg)
			fop_pkg::FOP_ST_SAMPLE: begin
				if (settle_reg == 10'(fop_pkg::STRAP_SETTLE_CYC - 1)) begin
					cfg13_next = filt_reg[fop_pkg::PIN_INT];
					dev_next = !filt_reg[fop_pkg::PIN_GP2];
					st_next = fop_pkg::FOP_ST_RUN;
				end else begin
					settle_next = settle_reg + 10'h001;
				end
			end
			fop_pkg::FOP_ST_RUN: begin
				st_next = fop_pkg::FOP_ST_RUN;
			end
			default: begin
				st_next = fop_pkg::FOP_ST_SAMPLE;
			end
		endcase
	end
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			st_reg <= fop_pkg::FOP_ST_SAMPLE;
			settle_reg <= 10'h000;
			cfg13_reg <= 1'h0;
			dev_reg <= 1'h0;
		end else if (ce) begin
			st_reg <= st_next;
			settle_reg <= settle_next;
			cfg13_reg <= cfg13_next;
			dev_reg <= dev_next;
		end
	end
	assign started = (st_reg == fop_pkg::FOP_ST_RUN);
	assign configOneThree = cfg13_reg;
	assign devMode = dev_reg;

	// Software registers
	logic [fop_pkg::PIN_CFG_W-1:0] pinCfg_reg;
	logic [fop_pkg::PIN_CFG_W-1:0] pinCfg_next;
	logic [1:0] failForce_reg;
	logic [1:0] failForce_next;
	logic [1:0] wakeEn_reg;
	logic [1:0] wakeEn_next;
	logic [fop_pkg::IRQ_W-1:0] irqEn_reg;
	logic [fop_pkg::IRQ_W-1:0] irqEn_next;
	logic [fop_pkg::IRQ_W-1:0] irqStat_reg;
	logic [fop_pkg::IRQ_W-1:0] irqStat_next;
	logic [31:0] rd_reg;
	logic [31:0] rd_next;
	logic [3:0] lvlPrev_reg;
	logic [3:0] lvlPrev_next;
	logic failPrev_reg;
	logic irq_reg;
	logic irq_next;
	logic intLow_reg;
	logic intLow_next;
	logic [fop_pkg::IRQ_W-1:0] events;
	logic [3:0] lvlNow;
	logic [3:0] lvlWatch;
	logic [1:0] gpGen;
	logic [1:0] gpOn;
	logic [1:0] gpMode [2];
	logic [6:0] levelStatus;
	logic wrEn;

	assign gpGen = {pinCfg_reg[fop_pkg::PC_GP2_GEN], pinCfg_reg[fop_pkg::PC_GP1_GEN]};
	assign gpOn = {pinCfg_reg[fop_pkg::PC_GP2_ON], pinCfg_reg[fop_pkg::PC_GP1_ON]};
	assign gpMode[0] = pinCfg_reg[fop_pkg::PC_GP1_MODE +: 2];
	assign gpMode[1] = pinCfg_reg[fop_pkg::PC_GP2_MODE +: 2];
	assign lvlNow = {filt_reg[fop_pkg::PIN_GP2], filt_reg[fop_pkg::PIN_GP1],
		filt_reg[fop_pkg::PIN_WAKE2], filt_reg[fop_pkg::PIN_WAKE1]};
	assign levelStatus = {started, dev_reg, cfg13_reg, lvlNow};
	assign wrEn = psel && penable && pwrite;

	// Wake watch: measurement takes both wake pins out together, general pins only in wake mode
	always_comb begin
		lvlWatch[0] = wakeEn_reg[0] && !pinCfg_reg[fop_pkg::PC_HV_MEAS];
		lvlWatch[1] = wakeEn_reg[1] && !pinCfg_reg[fop_pkg::PC_HV_MEAS];
		lvlWatch[2] = gpGen[0] && (gpMode[0] == fop_pkg::MODE_WAKE);
		lvlWatch[3] = gpGen[1] && (gpMode[1] == fop_pkg::MODE_WAKE);
		events = '0;
		events[3:0] = started ? (lvlWatch & (lvlNow ^ lvlPrev_reg)) : 4'h0;
		events[fop_pkg::IRQ_FAIL] = failDetect && !failPrev_reg;
		lvlPrev_next = lvlNow;
	end

	// Register writes, sticky status with set winning over clear, read data captured in setup
	always_comb begin
		pinCfg_next = pinCfg_reg;
		failForce_next = failForce_reg;
		wakeEn_next = wakeEn_reg;
		irqEn_next = irqEn_reg;
		irqStat_next = irqStat_reg;
		rd_next = rd_reg;
		if (wrEn) begin
			case (paddr)
				fop_pkg::ADDR_PIN_CFG: pinCfg_next = pwdata[fop_pkg::PIN_CFG_W-1:0];
				fop_pkg::ADDR_FAIL_CTRL: failForce_next = pwdata[1:0];
				fop_pkg::ADDR_WAKE_ENABLE_CONTROL: wakeEn_next = pwdata[1:0];
				fop_pkg::ADDR_IRQ_CLR: irqStat_next = irqStat_reg & ~pwdata[fop_pkg::IRQ_W-1:0];
				fop_pkg::ADDR_IRQ_EN: irqEn_next = pwdata[fop_pkg::IRQ_W-1:0];
				default: begin
				end
			endcase
		end
		irqStat_next = irqStat_next | events;
		if (psel && !penable) begin
			rd_next = 32'h0000_0000;
			case (paddr)
				fop_pkg::ADDR_PIN_CFG: rd_next[fop_pkg::PIN_CFG_W-1:0] = pinCfg_reg;
				fop_pkg::ADDR_FAIL_CTRL: rd_next[1:0] = failForce_reg;
				fop_pkg::ADDR_WAKE_ENABLE_CONTROL: rd_next[1:0] = wakeEn_reg;
				fop_pkg::ADDR_WAKE_LEVEL_STATUS: rd_next[6:0] = levelStatus;
				fop_pkg::ADDR_IRQ_STAT: rd_next[fop_pkg::IRQ_W-1:0] = irqStat_reg;
				fop_pkg::ADDR_IRQ_EN: rd_next[fop_pkg::IRQ_W-1:0] = irqEn_reg;
				default: rd_next = 32'h0000_0000;
			endcase
		end
		irq_next = |(irqStat_reg & irqEn_reg);
		// Wake flags only count in stop or normal mode, failures always
		intLow_next = started && (((|(irqStat_reg[3:0] & irqEn_reg[3:0])) && stopOrNormal) ||
			(irqStat_reg[fop_pkg::IRQ_FAIL] && irqEn_reg[fop_pkg::IRQ_FAIL]));
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pinCfg_reg <= fop_pkg::PIN_CFG_RST;
			failForce_reg <= fop_pkg::FAIL_CTRL_RST;
			wakeEn_reg <= fop_pkg::WAKE_EN_RST;
			irqEn_reg <= fop_pkg::IRQ_EN_RST;
			irqStat_reg <= '0;
			rd_reg <= 32'h0000_0000;
			lvlPrev_reg <= 4'h0;
			failPrev_reg <= 1'h0;
			irq_reg <= 1'h0;
			intLow_reg <= 1'h0;
		end else if (ce) begin
			pinCfg_reg <= pinCfg_next;
			failForce_reg <= failForce_next;
			wakeEn_reg <= wakeEn_next;
			irqEn_reg <= irqEn_next;
			irqStat_reg <= irqStat_next;
			rd_reg <= rd_next;
			lvlPrev_reg <= lvlPrev_next;
			failPrev_reg <= failDetect;
			irq_reg <= irq_next;
			intLow_reg <= intLow_next;
		end
	end

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready = 1'h1;
	assign pslverr = psel && penable && !addrMapped(paddr);
	assign prdata = rd_reg;
	assign irq = irq_reg;
	assign hvMeasureSelect = pinCfg_reg[fop_pkg::PC_HV_MEAS];

	// Interrupt pin released during start-up so the pull-up strap can be read
	assign intPinOut = 1'h0;
	assign intPinOeN = !intLow_reg;

	// Blink pattern sources, one per fail pin
	logic [1:0] failRun;
	logic [1:0] blinkLow;
	assign failRun = {2{started}} & ~gpGen & ({2{failDetect}} | failForce_reg);

	fop_blink #(
		.PERIOD_CYC(SIDE_PERIOD_CYC),
		.LOW_CYC(SIDE_LOW_CYC)
	) u_side_blink (
		.clk(clk),
		.rstN(rstN),
		.ce(ce),
		.run(failRun[0]),
		.lowPhase(blinkLow[0])
	);

	fop_blink #(
		.PERIOD_CYC(PULSE_PERIOD_CYC),
		.LOW_CYC(PULSE_LOW_CYC)
	) u_pulse_blink (
		.clk(clk),
		.rstN(rstN),
		.ce(ce),
		.run(failRun[1]),
		.lowPhase(blinkLow[1])
	);

	// Dual-function pin drivers; the fail pattern only reaches a pin left in fail function
	logic [1:0] pinOeN;
	logic [1:0] pinHs;
	for (genvar i = 0; i < 2; i++) begin : g_dual
		logic oeN_reg;
		logic oeN_next;
		logic hs_reg;
		logic hs_next;
		always_comb begin
			oeN_next = 1'h1;
			hs_next = 1'h0;
			if (started) begin
				if (gpGen[i]) begin
					oeN_next = !((gpMode[i] == fop_pkg::MODE_LOW_SIDE) && gpOn[i]);
					hs_next = (gpMode[i] == fop_pkg::MODE_HIGH_SIDE) && gpOn[i];
				end else begin
					oeN_next = !(failRun[i] && blinkLow[i]);
				end
			end
		end
		always_ff @(posedge clk or negedge rstN) begin
			if (!rstN) begin
				oeN_reg <= 1'h1;
				hs_reg <= 1'h0;
			end else if (ce) begin
				oeN_reg <= oeN_next;
				hs_reg <= hs_next;
			end
		end
		assign pinOeN[i] = oeN_reg;
		assign pinHs[i] = hs_reg;
	end

	// Open drain: the pad only ever pulls low
	assign sideIndicatorFailOut = 1'h0;
	assign sideIndicatorFailOeN = pinOeN[0];
	assign pulsedLightFailOut = 1'h0;
	assign pulsedLightFailOeN = pinOeN[1];
	assign generalPinOneHsOn = pinHs[0];
	assign generalPinTwoHsOn = pinHs[1];
endmodule

// >>> bench/fop_board.sv
`timescale 1ns/1ps
// Board around the pins: resistors, strap wiring, open-drain wires
module fop_board (
	input wire logic intOeN,
	input wire logic sideOeN,
	input wire logic pulseOeN,
	input wire logic pullUp,
	input wire logic testLow,
	output logic intPin,
	output logic sidePin,
	output logic pulsePin
);
	// A low enable pulls a wire down; otherwise its resistor sets it
	assign intPin = intOeN & pullUp;
	assign sidePin = sideOeN;
	// Internal pull-up unless the strap grounds the pin
	assign pulsePin = pulseOeN & ~testLow;
endmodule

// >>> bench/fop_pin_logic_props.sv
`timescale 1ns/1ps
module fop_pin_props #(
	parameter int unsigned SIDE_LOW_CYC = 20,
	parameter int unsigned PULSE_LOW_CYC = 2
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic intPinOeN,
	input wire logic sideIndicatorFailOeN,
	input wire logic pulsedLightFailOeN,
	input wire logic generalPinOneHsOn,
	input wire logic hvMeasureSelect,
	input wire logic configOneThree,
	input wire logic devMode,
	input wire logic irq
);
	logic [8:0] cfgReg;
	logic [9:0] upReg;
	logic [31:0] sideReg, pulseReg;
	logic badAddr, hsWant;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Decoded bus address and shadowed config
	assign badAddr = paddr > 8'h18 || paddr[1:0] != 2'h0;
	assign hsWant = cfgReg[0] && cfgReg[2:1] == 2'h2 && cfgReg[7];
	// Config shadow, time since reset, low runs of fail pins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfgReg <= 9'h000;
			upReg <= 10'h000;
			sideReg <= 32'h0000_0000;
			pulseReg <= 32'h0000_0000;
		end else begin
			if (psel && penable && pwrite && paddr == fop_pkg::ADDR_PIN_CFG) begin
				cfgReg <= pwdata[8:0];
			end
			upReg <= (upReg == 10'h3FF) ? upReg : upReg + 10'h001;
			// General-pin use may hold a pin low, so it clears the count
			// Wide enough for full-length phases, so the bound never wraps away
			sideReg <= (!sideIndicatorFailOeN && !cfgReg[0]) ? sideReg + 32'h0000_0001 :
				32'h0000_0000;
			pulseReg <= (!pulsedLightFailOeN && !cfgReg[3]) ? pulseReg + 32'h0000_0001 :
				32'h0000_0000;
		end
	end
	bus_error_a: assert property (psel && penable |-> pslverr == badAddr)
		else $error("bus error flag wrong");
	int_cause_a: assert property (!intPinOeN |-> irq || $past(irq))
		else $error("interrupt pin low without cause");
	side_low_a: assert property (sideReg <= SIDE_LOW_CYC)
		else $error("side low phase too long");
	pulse_low_a: assert property (pulseReg <= PULSE_LOW_CYC)
		else $error("pulse low phase too long");
	high_side_a: assert property (generalPinOneHsOn |-> $past(hsWant))
		else $error("high side on without setting");
	start_quiet_a: assert property (upReg < 10'h1F4 |->
		intPinOeN && sideIndicatorFailOeN && pulsedLightFailOeN)
		else $error("pin driven before start");
	strap_hold_a: assert property (upReg > 10'h1FD |->
		$stable(devMode) && $stable(configOneThree))
		else $error("strap result changed");
	meas_sel_a: assert property (hvMeasureSelect == cfgReg[6])
		else $error("measure select wrong");
	cover property ($fell(sideIndicatorFailOeN));
	cover property ($rose(irq));
	cover property (psel && penable && pslverr);
endmodule
bind fop_pin_logic fop_pin_props #(.SIDE_LOW_CYC(SIDE_LOW_CYC), .PULSE_LOW_CYC(PULSE_LOW_CYC))
	props_u (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .intPinOeN,
	.sideIndicatorFailOeN, .pulsedLightFailOeN, .generalPinOneHsOn, .hvMeasureSelect,
	.configOneThree, .devMode, .irq);

// >>> bench/fop_pin_logic_test.sv
`timescale 1ns/1ps
module fop_pin_logic_test;
	// Short blink counts keep the run brief
	localparam int unsigned SP = 40;
	localparam int unsigned SL = 20;
	localparam int unsigned PP = 10;
	localparam int unsigned PL = 2;
	logic clk, pready, pslverr, intPin, intOeN, sidePin, sideOeN, pulsePin, pulseOeN;
	logic hs1, hs2, hvSel, cfg13, devMode, irq, pullUp, testLow;
	logic arstN = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, measV = 1'b0;
	logic stopOrNormal = 1'b0, failDetect = 1'b0, wakeOne = 1'b0, wakeTwo = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h1C};
	logic [31:0] pwdata = 32'h0000_0000, meas = 32'h0000_0000;
	logic [31:0] prdata, got, ex;
	logic [31:0] expQ[$];
	int mismatches, checked;
	fop_pin_logic #(.SIDE_PERIOD_CYC(SP), .SIDE_LOW_CYC(SL), .PULSE_PERIOD_CYC(PP),
		.PULSE_LOW_CYC(PL)) dut_u (.clk(clk), .arst_n(arstN), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .stopOrNormal(stopOrNormal),
		.failDetect(failDetect), .intPinIn(intPin), .intPinOut(), .intPinOeN(intOeN),
		.wakeInputOne(wakeOne), .wakeInputTwo(wakeTwo), .hvMeasureSelect(hvSel),
		.sideIndicatorFailIn(sidePin), .sideIndicatorFailOut(), .sideIndicatorFailOeN(sideOeN),
		.pulsedLightFailIn(pulsePin), .pulsedLightFailOut(), .pulsedLightFailOeN(pulseOeN),
		.generalPinOneHsOn(hs1), .generalPinTwoHsOn(hs2), .configOneThree(cfg13),
		.devMode(devMode), .irq(irq));
	fop_board board_u (.intOeN(intOeN), .sideOeN(sideOeN), .pulseOeN(pulseOeN),
		.pullUp(pullUp), .testLow(testLow), .intPin(intPin), .sidePin(sidePin),
		.pulsePin(pulsePin));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// One APB transfer; waits for pready however long it takes
	task automatic apb(input logic wr, input logic [7:0] a, input logic [8:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {23'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		// No limit here; only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [8:0] e);
		expQ.push_back({23'h0, e});
		apb(1'b0, a, 9'h000);
	endtask
	// Hands a sampled value to the monitor as a result
	task automatic put(input logic [8:0] e, input logic [8:0] v);
		expQ.push_back({23'h0, e});
		@(posedge clk);
		meas <= {23'h0, v};
		measV <= 1'b1;
		@(posedge clk);
		measV <= 1'b0;
	endtask
	// Length of the next whole run of one level; skips a partial run first
	task automatic run(input logic p, input logic lv, input logic [8:0] e);
		int n;
		int k;
		n = 0;
		k = 0;
		for (int f = 0; f < 3; f++) begin
			while ((((p ? pulseOeN : sideOeN) === lv) == (f != 1)) && k < 999) begin
				@(posedge clk);
				k++;
				n += (f == 2);
			end
		end
		put(e, 9'(n));
	endtask
	task automatic close_out();
		if (mismatches == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Compares every result with the oldest expectation
	always @(posedge clk) begin
		if ((psel & penable & ~pwrite & pready) === 1'b1 || measV === 1'b1) begin
			checked++;
			got = measV ? meas : prdata;
			ex = (expQ.size() > 0) ? expQ.pop_front() : ~got;
			if (got !== ex) begin
				mismatches++;
				$display("[FAIL] t=%0t exp=%h got=%h", $time, ex, got);
			end
		end
	end
	// Main sequence
	initial begin
		void'($urandom(38756));
		pullUp = 1'($urandom);
		testLow = 1'($urandom);
		repeat (5) @(posedge clk);
		arstN <= 1'b1;
		repeat (520) @(posedge clk);
		put({7'h00, pullUp, testLow}, {7'h00, cfg13, devMode});
		rd(fop_pkg::ADDR_WAKE_LEVEL_STATUS, {3'h1, testLow, pullUp, ~testLow, 3'h4});
		// Unmapped and read-only writes must leave nothing behind
		apb(1'b1, 8'h1C, 9'h1FF);
		apb(1'b1, fop_pkg::ADDR_IRQ_STAT, 9'h01F);
		for (int i = 0; i < 6; i++) begin
			rd(ra[i], (ra[i] == 8'h08) ? 9'h003 : 9'h000);
		end
		put(9'h007, {6'h00, intOeN, sideOeN, pulseOeN});
		apb(1'b1, fop_pkg::ADDR_FAIL_CTRL, 9'h003);
		run(1'b0, 1'b0, 9'(SL));
		run(1'b0, 1'b1, 9'(SP - SL));
		run(1'b1, 1'b0, 9'(PL));
		run(1'b1, 1'b1, 9'(PP - PL));
		// Both pins general in each mode, switch on, patterns still forced
		// Low side first, so wake mode then sees pin one rise, and pin two too unless testLow grounds it
		for (int m = 1; m < 3; m = (m == 1) ? 0 : m + 2) begin
			apb(1'b1, fop_pkg::ADDR_PIN_CFG, 9'h189 | 9'(m * 18));
			repeat (4) @(posedge clk);
			put({5'h0, m == 2, m == 2, m != 1, m != 1}, {5'h0, hs1, hs2, sideOeN, pulseOeN});
		end
		rd(fop_pkg::ADDR_IRQ_STAT, testLow ? 9'h004 : 9'h00C);
		apb(1'b1, fop_pkg::ADDR_IRQ_CLR, 9'h01F);
		apb(1'b1, fop_pkg::ADDR_PIN_CFG, 9'h000);
		apb(1'b1, fop_pkg::ADDR_FAIL_CTRL, 9'h000);
		repeat (4) @(posedge clk);
		put(9'h007, {6'h00, intOeN, sideOeN, pulseOeN});
		// Failure: masked first, then enabled, then cleared
		failDetect <= 1'b1;
		repeat (4) @(posedge clk);
		rd(fop_pkg::ADDR_IRQ_STAT, 9'h010);
		put(9'h001, {7'h00, irq, intOeN});
		apb(1'b1, fop_pkg::ADDR_IRQ_EN, 9'h011);
		repeat (3) @(posedge clk);
		put(9'h002, {7'h00, irq, intOeN});
		apb(1'b1, fop_pkg::ADDR_IRQ_CLR, 9'h010);
		failDetect <= 1'b0;
		repeat (3) @(posedge clk);
		put(9'h001, {7'h00, irq, intOeN});
		// Wake flag only reaches the pin in stop or normal mode
		stopOrNormal <= 1'b1;
		wakeOne <= 1'b1;
		repeat (8) @(posedge clk);
		put(9'h002, {7'h00, irq, intOeN});
		stopOrNormal <= 1'b0;
		repeat (3) @(posedge clk);
		put(9'h003, {7'h00, irq, intOeN});
		apb(1'b1, fop_pkg::ADDR_IRQ_CLR, 9'h01F);
		apb(1'b1, fop_pkg::ADDR_PIN_CFG, 9'h040);
		apb(1'b1, fop_pkg::ADDR_WAKE_ENABLE_CONTROL, 9'h000);
		repeat (1 + $urandom % 6) begin
			wakeOne <= ~wakeOne;
			wakeTwo <= 1'($urandom);
			repeat (3) @(posedge clk);
		end
		repeat (8) @(posedge clk);
		rd(fop_pkg::ADDR_IRQ_STAT, 9'h000);
		repeat (2) @(posedge clk);
		close_out();
	end
	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		close_out();
	end
endmodule
